// [hw/dtc_pkg.sv]
// Shared constants of the dual timer with capture/reload register.
package dtc_pkg;
    // Bus geometry.
    localparam int DATA_W = 32;
    localparam int ADDR_W = 32;
    localparam int STRB_W = DATA_W / 8;
    // Register byte offsets.
    localparam logic [7:0] AUX_CTRL_OFS = 8'h00;
    localparam logic [7:0] CORE_CTRL_OFS = 8'h04;
    localparam logic [7:0] CAP_CTRL_OFS = 8'h08;
    localparam logic [7:0] AUX_CNT_OFS = 8'h0c;
    localparam logic [7:0] CORE_CNT_OFS = 8'h10;
    localparam logic [7:0] CAPTURE_RELOAD_REG_OFS = 8'h14;
    localparam logic [7:0] STATUS_OFS = 8'h18;
    localparam logic [7:0] MASK_OFS = 8'h1c;
    // Field positions shared by both timer control registers.
    localparam int F_RUN = 0;
    localparam int F_DOWN = 1;
    localparam int F_PSC_LO = 4;
    localparam int PSC_W = 3;
    // Auxiliary timer control fields.
    localparam int F_AUX_SRC_LO = 2;
    // Core timer control fields.
    localparam int F_CORE_EXTDIR = 2;
    localparam int F_CORE_SRC = 3;
    localparam int F_CORE_RELOAD = 7;
    localparam int F_CORE_OUTEN = 8;
    // Capture control fields.
    localparam int F_CAP_EDGE_LO = 0;
    localparam int F_CAP_CLR = 2;
    localparam int F_CAP_TRIG_LO = 3;
    // Status and mask bit positions.
    localparam int ST_CORE_OVF = 0;
    localparam int ST_CAPTURE = 1;
    localparam int ST_AUX_OVF = 2;
    localparam int ST_W = 3;
    // Reset values.
    localparam logic [DATA_W-1:0] CTRL_RST = 32'h0000_0000;
    localparam logic [ST_W-1:0] STATUS_RST = 3'h0;
    // Width of the free running prescaler counter.
    localparam int PRESC_W = 8;
    // Auxiliary timer clock sources.
    typedef enum logic [1:0] {
        AUX_SRC_PRESC = 2'b00,
        AUX_SRC_PIN = 2'b01,
        AUX_SRC_LATCH = 2'b10,
        AUX_SRC_OFF = 2'b11
    } dtc_aux_src_type;
    // Capture pin edge selection.
    typedef enum logic [1:0] {
        EDGE_NONE = 2'b00,
        EDGE_RISE = 2'b01,
        EDGE_FALL = 2'b10,
        EDGE_BOTH = 2'b11
    } dtc_edge_type;
    // Capture trigger selection.
    typedef enum logic [1:0] {
        TRIG_CAPTURE_INPUT_PIN = 2'b00,
        TRIG_PEER_CNT = 2'b01,
        TRIG_PEER_DIR = 2'b10,
        TRIG_PEER_BOTH = 2'b11
    } dtc_trig_type;
    // Bus responses.
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage : dtc_pkg

// [hw/dtc_timer.sv]
// Decided for this implementation: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
module dtc_timer #(
    parameter int TIMER_W = 16 // Timer width.
) (
    input logic aclk,
    input logic aresetn,
    input logic s_axi_awvalid,
    output logic s_axi_awready,
    input logic [dtc_pkg::ADDR_W-1:0] s_axi_awaddr,
    input logic [2:0] s_axi_awprot,
    input logic s_axi_wvalid,
    output logic s_axi_wready,
    input logic [dtc_pkg::DATA_W-1:0] s_axi_wdata,
    input logic [dtc_pkg::STRB_W-1:0] s_axi_wstrb,
    output logic s_axi_bvalid,
    input logic s_axi_bready,
    output logic [1:0] s_axi_bresp,
    input logic s_axi_arvalid,
    output logic s_axi_arready,
    input logic [dtc_pkg::ADDR_W-1:0] s_axi_araddr,
    input logic [2:0] s_axi_arprot,
    output logic s_axi_rvalid,
    input logic s_axi_rready,
    output logic [dtc_pkg::DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    input logic aux_count_input,
    input logic core_count_input,
    input logic core_direction_input,
    input logic capture_input_pin,
    input logic peer_count_input,
    input logic peer_direction_input,
    output logic toggle_output_pin,
    output logic core_overflow_pulse,
    output logic irq
);
    import dtc_pkg::*;

    // The register offsets only reserve 16 bits per count field.
    if (TIMER_W < 2 || TIMER_W > 16) begin : g_bad_width
        $error("TIMER_W must lie between 2 and 16.");
    end

    localparam logic [TIMER_W-1:0] CNT_ONE = TIMER_W'(1);
    localparam logic [TIMER_W-1:0] CNT_MAX = '1;
    localparam logic [PRESC_W-1:0] PRESC_ONE = PRESC_W'(1);

    ////////////////////////////////////////////////////////////////////////////////
    // State.

    // Every flip-flop of the block lives in this one record.
    typedef struct packed {
        logic [PRESC_W-1:0] presc;
        logic [TIMER_W-1:0] aux;
        logic [TIMER_W-1:0] core;
        logic [TIMER_W-1:0] capture_reload_reg;
        logic latch;
        logic [DATA_W-1:0] aux_ctrl;
        logic [DATA_W-1:0] core_ctrl;
        logic [DATA_W-1:0] cap_ctrl;
        logic [ST_W-1:0] status;
        logic [ST_W-1:0] mask;
        logic aux_in_q;
        logic core_in_q;
        logic cap_in_q;
        logic peer_cnt_q;
        logic peer_dir_q;
        logic aw_got;
        logic w_got;
        logic [7:0] awaddr;
        logic [DATA_W-1:0] wdata;
        logic [STRB_W-1:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [DATA_W-1:0] rdata;
        logic [1:0] rresp;
        logic tog_pin;
        logic ovf_pulse;
        logic irq;
    } dtc_state_type;

    dtc_state_type st; // Registered state.
    dtc_state_type next_st; // Next state.

    // Helper terms shared by the update logic and the checks.
    logic aw_hs, w_hs, ar_hs, wr_go, wr_ok;
    logic [7:0] wa;
    logic [DATA_W-1:0] wd;
    logic [STRB_W-1:0] ws;
    logic aux_wr, core_wr, capture_reload_reg_wr;
    logic core_tick, core_step, core_down, core_ovf;
    logic aux_tick, aux_step, aux_down, aux_ovf, cap_evt;
    logic [ST_W-1:0] st_set;
    dtc_aux_src_type aux_src;
    dtc_edge_type cap_edge;
    dtc_trig_type cap_trig;

    // Byte-lane merge of a write into a stored word.
    function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] old,
                                                input logic [DATA_W-1:0] val,
                                                input logic [STRB_W-1:0] strb);
        logic [DATA_W-1:0] res;
        res = old;
        for (int i = 0; i < STRB_W; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = val[i*8 +: 8];
            end
        end
        return res;
    endfunction : merge

    // Prescaler compare mask; the shortest period is two clocks.
    function automatic logic [PRESC_W-1:0] psc_mask(input logic [PSC_W-1:0] e);
        logic [PRESC_W:0] m;
        m = (9'h002 << e) - 9'h001;
        return m[PRESC_W-1:0];
    endfunction : psc_mask

    ////////////////////////////////////////////////////////////////////////////////
    // Next-state logic.

    // Bus decode first, then the timers, so software and hardware can be ranked.
    always_comb begin
        next_st = st;
        aw_hs = s_axi_awvalid && s_axi_awready;
        w_hs = s_axi_wvalid && s_axi_wready;
        ar_hs = s_axi_arvalid && s_axi_arready;
        // A write fires once address and data are both in, in either order.
        wr_go = (st.aw_got || aw_hs) && (st.w_got || w_hs) && !st.bvalid;
        wa = st.aw_got ? st.awaddr : s_axi_awaddr[7:0];
        wd = st.w_got ? st.wdata : s_axi_wdata;
        ws = st.w_got ? st.wstrb : s_axi_wstrb;
        wr_ok = 1'b1;
        aux_wr = 1'b0;
        core_wr = 1'b0;
        capture_reload_reg_wr = 1'b0;
        if (aw_hs) begin
            next_st.aw_got = 1'b1;
            next_st.awaddr = s_axi_awaddr[7:0];
        end
        if (w_hs) begin
            next_st.w_got = 1'b1;
            next_st.wdata = s_axi_wdata;
            next_st.wstrb = s_axi_wstrb;
        end
        if (wr_go) begin
            next_st.aw_got = 1'b0;
            next_st.w_got = 1'b0;
            unique case (wa)
                AUX_CTRL_OFS: next_st.aux_ctrl = merge(st.aux_ctrl, wd, ws);
                CORE_CTRL_OFS: next_st.core_ctrl = merge(st.core_ctrl, wd, ws);
                CAP_CTRL_OFS: next_st.cap_ctrl = merge(st.cap_ctrl, wd, ws);
                AUX_CNT_OFS: aux_wr = 1'b1;
                CORE_CNT_OFS: core_wr = 1'b1;
                CAPTURE_RELOAD_REG_OFS: capture_reload_reg_wr = 1'b1;
                STATUS_OFS: ;
                MASK_OFS: next_st.mask = ws[0] ? wd[ST_W-1:0] : st.mask;
                default: wr_ok = 1'b0;
            endcase
            next_st.bvalid = 1'b1;
            next_st.bresp = wr_ok ? RESP_OKAY : RESP_SLVERR;
        end else if (st.bvalid && s_axi_bready) begin
            next_st.bvalid = 1'b0;
        end
        // Reads sample the registers as they stand at the address edge.
        if (ar_hs) begin
            next_st.rvalid = 1'b1;
            next_st.rresp = RESP_OKAY;
            unique case (s_axi_araddr[7:0])
                AUX_CTRL_OFS: next_st.rdata = st.aux_ctrl;
                CORE_CTRL_OFS: next_st.rdata = st.core_ctrl;
                CAP_CTRL_OFS: next_st.rdata = st.cap_ctrl;
                AUX_CNT_OFS: next_st.rdata = 32'(st.aux);
                CORE_CNT_OFS: next_st.rdata = 32'(st.core);
                CAPTURE_RELOAD_REG_OFS: next_st.rdata = 32'(st.capture_reload_reg);
                STATUS_OFS: next_st.rdata = 32'(st.status);
                MASK_OFS: next_st.rdata = 32'(st.mask);
                default: begin
                    next_st.rdata = CTRL_RST;
                    next_st.rresp = RESP_SLVERR;
                end
            endcase
        end else if (st.rvalid && s_axi_rready) begin
            next_st.rvalid = 1'b0;
        end

        // Pin history for edge detection.
        next_st.aux_in_q = aux_count_input;
        next_st.core_in_q = core_count_input;
        next_st.cap_in_q = capture_input_pin;
        next_st.peer_cnt_q = peer_count_input;
        next_st.peer_dir_q = peer_direction_input;
        next_st.presc = st.presc + PRESC_ONE;

        // Core timer: prescaled clock or rising pin edge; an edge needs two
        // samples, so no source steps faster than every second clock.
        if (st.core_ctrl[F_CORE_SRC]) begin
            core_tick = core_count_input && !st.core_in_q;
        end else begin
            core_tick = (st.presc & psc_mask(st.core_ctrl[F_PSC_LO +: PSC_W]))
                        == psc_mask(st.core_ctrl[F_PSC_LO +: PSC_W]);
        end
        core_step = core_tick && st.core_ctrl[F_RUN];
        // Direction from software or, if chosen, the external level.
        core_down = st.core_ctrl[F_CORE_EXTDIR] ? core_direction_input
                                                : st.core_ctrl[F_DOWN];
        core_ovf = core_step && (core_down ? st.core == '0 : st.core == CNT_MAX);
        if (core_ovf && st.core_ctrl[F_CORE_RELOAD]) begin
            next_st.core = st.capture_reload_reg;
        end else if (core_step) begin
            next_st.core = core_down ? st.core - CNT_ONE : st.core + CNT_ONE;
        end
        next_st.latch = st.latch ^ core_ovf;
        next_st.ovf_pulse = core_ovf;

        // Aux timer: prescaler, pin, or each toggle latch change.
        aux_src = dtc_aux_src_type'(st.aux_ctrl[F_AUX_SRC_LO +: 2]);
        unique case (aux_src)
            AUX_SRC_PRESC: aux_tick = (st.presc & psc_mask(st.aux_ctrl[F_PSC_LO +: PSC_W]))
                                      == psc_mask(st.aux_ctrl[F_PSC_LO +: PSC_W]);
            AUX_SRC_PIN: aux_tick = aux_count_input && !st.aux_in_q;
            AUX_SRC_LATCH: aux_tick = core_ovf;
            AUX_SRC_OFF: aux_tick = 1'b0;
        endcase
        aux_step = aux_tick && st.aux_ctrl[F_RUN];
        // No direction pin reaches this timer; software alone steers it.
        aux_down = st.aux_ctrl[F_DOWN];
        aux_ovf = aux_step && (aux_down ? st.aux == '0 : st.aux == CNT_MAX);
        if (aux_step) begin
            next_st.aux = aux_down ? st.aux - CNT_ONE : st.aux + CNT_ONE;
        end

        // Capture trigger: pin edge or peer transitions.
        cap_edge = dtc_edge_type'(st.cap_ctrl[F_CAP_EDGE_LO +: 2]);
        cap_trig = dtc_trig_type'(st.cap_ctrl[F_CAP_TRIG_LO +: 2]);
        unique case (cap_trig)
            TRIG_CAPTURE_INPUT_PIN: cap_evt =
                ((cap_edge == EDGE_RISE || cap_edge == EDGE_BOTH)
                 && capture_input_pin && !st.cap_in_q)
                || ((cap_edge == EDGE_FALL || cap_edge == EDGE_BOTH)
                    && !capture_input_pin && st.cap_in_q);
            TRIG_PEER_CNT: cap_evt = peer_count_input != st.peer_cnt_q;
            TRIG_PEER_DIR: cap_evt = peer_direction_input != st.peer_dir_q;
            TRIG_PEER_BOTH: cap_evt = (peer_count_input != st.peer_cnt_q)
                                      || (peer_direction_input != st.peer_dir_q);
        endcase
        // Software may load the capture register; a capture in the same
        // cycle wins so a measurement is never lost.
        if (capture_reload_reg_wr) begin
            next_st.capture_reload_reg = TIMER_W'(merge(32'(st.capture_reload_reg), wd, ws));
        end
        if (cap_evt) begin
            next_st.capture_reload_reg = st.aux;
            if (st.cap_ctrl[F_CAP_CLR]) begin
                next_st.aux = '0;
            end
        end
        // A software load of a count overrides the timer's own step.
        if (aux_wr) begin
            next_st.aux = TIMER_W'(merge(32'(st.aux), wd, ws));
        end
        if (core_wr) begin
            next_st.core = TIMER_W'(merge(32'(st.core), wd, ws));
        end

        // Sticky events; a new event beats a write-one-to-clear.
        st_set = '0;
        st_set[ST_CORE_OVF] = core_ovf;
        st_set[ST_CAPTURE] = cap_evt;
        st_set[ST_AUX_OVF] = aux_ovf;
        if (wr_go && wa == STATUS_OFS && ws[0]) begin
            next_st.status = st.status & ~wd[ST_W-1:0];
        end
        next_st.status = next_st.status | st_set;
        next_st.irq = |(next_st.status & next_st.mask);
        next_st.tog_pin = next_st.latch && next_st.core_ctrl[F_CORE_OUTEN];
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Registers.

    // Synchronous reset clears all state.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st <= '0;
            st.aux_ctrl <= CTRL_RST;
            st.core_ctrl <= CTRL_RST;
            st.cap_ctrl <= CTRL_RST;
            st.status <= STATUS_RST;
            st.mask <= STATUS_RST;
        end else begin
            st <= next_st;
        end
    end

    // Ready outputs are combinational; valid and data outputs are flops.
    assign s_axi_awready = !st.aw_got && !st.bvalid;
    assign s_axi_wready = !st.w_got && !st.bvalid;
    assign s_axi_arready = !st.rvalid;
    assign s_axi_bvalid = st.bvalid;
    assign s_axi_bresp = st.bresp;
    assign s_axi_rvalid = st.rvalid;
    assign s_axi_rdata = st.rdata;
    assign s_axi_rresp = st.rresp;
    assign toggle_output_pin = st.tog_pin;
    assign core_overflow_pulse = st.ovf_pulse;
    assign irq = st.irq;

    ////////////////////////////////////////////////////////////////////////////////
    // Checks.

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_ovf;
        core_ovf;
    endsequence
    sequence s_flip;
        st.latch != $past(st.latch);
    endsequence
    sequence s_capture;
        cap_evt && !aux_wr;
    endsequence

    a_latch_toggle: assert property (s_ovf |=> s_flip)
        else $error("Toggle latch did not flip on core overflow.");
    a_ovf_pulse: assert property (core_ovf |=> core_overflow_pulse ##1
                                  (core_overflow_pulse == $past(core_ovf)))
        else $error("Overflow pulse does not follow the core overflow.");
    a_core_reload: assert property (core_ovf && st.core_ctrl[F_CORE_RELOAD] && !core_wr
                                    |=> st.core == $past(st.capture_reload_reg))
        else $error("Core timer was not reloaded.");
    a_capture_value: assert property (cap_evt |=> st.capture_reload_reg == $past(st.aux))
        else $error("Capture register missed the aux count.");
    a_clear_after: assert property (s_capture and st.cap_ctrl[F_CAP_CLR]
                                    |=> st.aux == '0)
        else $error("Aux timer not cleared after capture.");
    a_step_rate: assert property (core_step |=> !core_step)
        else $error("Core timer stepped on two adjacent clocks.");
    a_toggle_pin: assert property (core_ovf && st.core_ctrl[F_CORE_OUTEN] && !wr_go
                                   |=> toggle_output_pin != $past(toggle_output_pin))
        else $error("Toggle pin did not follow the latch.");
    a_ext_dir: assert property (core_step && st.core_ctrl[F_CORE_EXTDIR] && !core_ovf
                                && core_direction_input && !core_wr
                                |=> st.core == $past(st.core) - CNT_ONE)
        else $error("External direction did not count down.");
    a_aux_soft_dir: assert property (aux_step && !st.aux_ctrl[F_DOWN] && !aux_ovf
                                     && !cap_evt && !aux_wr
                                     |=> st.aux == $past(st.aux) + CNT_ONE)
        else $error("Aux timer ignored its software direction.");
    a_peer_trig: assert property (st.cap_ctrl[F_CAP_TRIG_LO +: 2] == TRIG_PEER_BOTH
                                  && (peer_direction_input != st.peer_dir_q
                                      || peer_count_input != st.peer_cnt_q)
                                  |=> st.status[ST_CAPTURE])
        else $error("Peer transition did not capture.");
endmodule : dtc_timer

// [test/dtc_pin_model.sv]
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Far side of the timer: event pins and the neighbouring timer's lines.
// These are push-pull inputs of the device, so the model drives them at all times.
module dtc_pin_model (
    input logic aclk,
    output logic aux_count_input,
    output logic core_count_input,
    output logic core_direction_input,
    output logic capture_input_pin,
    output logic peer_count_input,
    output logic peer_direction_input,
    input logic core_overflow_pulse
);
    // Pin levels: aux clock, core clock, core dir, capture, peer clock, peer dir.
    logic [5:0] pins = 6'h00;
    // Overflow events handed on to the capture/compare unit, counted here.
    int ovf_seen = 0;
    assign {peer_direction_input, peer_count_input, capture_input_pin,
            core_direction_input, core_count_input, aux_count_input} = pins;
    ////////////////////////////////////////////////////////////////////////////////
    // The unit counts a clock per pulse, so each pulse must be seen exactly once.
    always @(posedge aclk) begin
        if (core_overflow_pulse === 1'b1) ovf_seen <= ovf_seen + 1;
    end
    // Two clocks high and two low, so the sampler cannot miss either edge.
    task automatic pulse(input int idx, input int n);
        repeat (n) begin
            @(posedge aclk);
            pins[idx] <= 1'b1;
            repeat (2) @(posedge aclk);
            pins[idx] <= 1'b0;
            repeat (2) @(posedge aclk);
        end
    endtask : pulse
    // A level change, then time for the sampler to register it.
    task automatic set_level(input int idx, input logic lvl);
        @(posedge aclk);
        pins[idx] <= lvl;
        repeat (3) @(posedge aclk);
    endtask : set_level
endmodule : dtc_pin_model

// [test/dual_timer_capture_reload_test.sv]
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Self-checking bench: register bus tasks, the pin model and the scenarios.
module dual_timer_capture_reload_test;
    import dtc_pkg::*;
    localparam int AUXP = 0;
    localparam int CORP = 1;
    localparam int DIRP = 2;
    localparam int CAPP = 3;
    localparam int PCNT = 4;
    logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, v, rd;
    logic [3:0] s_axi_wstrb;
    logic [2:0] s_axi_awprot, s_axi_arprot;
    logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
    logic aux_count_input, core_count_input, core_direction_input, capture_input_pin;
    logic peer_count_input, peer_direction_input, toggle_output_pin, core_overflow_pulse, irq;
    // Registers whose reset value is all zeros.
    logic [7:0] ofs [5] = '{AUX_CTRL_OFS, CORE_CTRL_OFS, CAP_CTRL_OFS, STATUS_OFS, MASK_OFS};
    int failures = 0;
    int checked = 0;
    int cyc = 0;
    int t0, p;
    dtc_timer i_dut (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
        .s_axi_awprot, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready,
        .s_axi_araddr, .s_axi_arprot, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
        .s_axi_rresp, .aux_count_input, .core_count_input, .core_direction_input,
        .capture_input_pin, .peer_count_input, .peer_direction_input, .toggle_output_pin,
        .core_overflow_pulse, .irq);
    dtc_pin_model i_pins (.aclk, .aux_count_input, .core_count_input, .core_direction_input,
        .capture_input_pin, .peer_count_input, .peer_direction_input, .core_overflow_pulse);
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        aclk = 1'b0;
        forever #50 aclk = ~aclk;
    end
    // Cycle count, used to bound the prescaler window.
    always @(posedge aclk) cyc <= cyc + 1;
    task automatic close_out;
        if (failures == 0 && checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : close_out
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            failures++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    // Handshakes are judged from levels at the falling edge; inputs move only on rising ones.
    task automatic axi_write(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
        logic aw_ok, w_ok, b_ok;
        b_ok = 1'b0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        {s_axi_awvalid, s_axi_wvalid} <= 2'h3;
        for (int n = 0; n < 50 && !b_ok; n++) begin
            @(negedge aclk);
            aw_ok = s_axi_awvalid && s_axi_awready;
            w_ok = s_axi_wvalid && s_axi_wready;
            b_ok = s_axi_bvalid;
            r = s_axi_bresp;
            @(posedge aclk);
            if (aw_ok) s_axi_awvalid <= 1'b0;
            if (w_ok) s_axi_wvalid <= 1'b0;
        end
        if (!b_ok) begin
            failures++;
            close_out();
        end
    endtask : axi_write
    task automatic axi_read(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
        logic ar_ok, r_ok;
        r_ok = 1'b0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        for (int n = 0; n < 50 && !r_ok; n++) begin
            @(negedge aclk);
            ar_ok = s_axi_arvalid && s_axi_arready;
            r_ok = s_axi_rvalid;
            {r, d} = {s_axi_rresp, s_axi_rdata};
            @(posedge aclk);
            if (ar_ok) s_axi_arvalid <= 1'b0;
        end
        if (!r_ok) begin
            failures++;
            close_out();
        end
    endtask : axi_read
    task automatic wr(input logic [7:0] o, input logic [31:0] d);
        logic [1:0] r;
        axi_write({24'h00_0000, o}, d, r);
        check({30'h0, r}, {30'h0, RESP_OKAY});
    endtask : wr
    task automatic chk(input logic [7:0] o, input logic [31:0] exp);
        logic [1:0] r;
        logic [31:0] d;
        axi_read({24'h00_0000, o}, d, r);
        check({30'h0, r}, {30'h0, RESP_OKAY});
        check(d, exp);
    endtask : chk
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        aresetn = 1'b0;
        // Response ready lines stay high, so back-to-back calls never re-drive them.
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h05;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        s_axi_wstrb = 4'hf;
        {s_axi_awprot, s_axi_arprot} = 6'h00;
        void'($urandom(32'hf011));
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        for (int i = 0; i < 5; i++) chk(ofs[i], 32'h0000_0000);
        // An unmapped word answers with an error and zero data.
        axi_write(32'h0000_0020, 32'h0000_0001, rsp);
        check({30'h0, rsp}, {30'h0, RESP_SLVERR});
        axi_read(32'h0000_0020, rd, rsp);
        check({30'h0, rsp}, {30'h0, RESP_SLVERR});
        check(rd, 32'h0000_0000);
        // Core from its pin, output on: wrap through the 16-bit top.
        wr(CORE_CTRL_OFS, 32'h0000_0109);
        wr(CORE_CNT_OFS, 32'h0000_fffe);
        i_pins.pulse(CORP, 3);
        chk(CORE_CNT_OFS, 32'h0000_0001);
        check({31'h0, toggle_output_pin}, 32'h0000_0001);
        check(i_pins.ovf_seen, 1);
        // Direction taken from the external line, underflow through zero.
        wr(CORE_CTRL_OFS, 32'h0000_010d);
        i_pins.set_level(DIRP, 1'b1);
        i_pins.pulse(CORP, 2);
        chk(CORE_CNT_OFS, 32'h0000_ffff);
        check({31'h0, toggle_output_pin}, 32'h0000_0000);
        check(i_pins.ovf_seen, 2);
        i_pins.set_level(DIRP, 1'b0);
        // Interrupt: raise by mask, drop by clearing the sticky bit.
        chk(STATUS_OFS, 32'h0000_0001);
        wr(MASK_OFS, 32'h0000_0001);
        check({31'h0, irq}, 32'h0000_0001);
        wr(STATUS_OFS, 32'h0000_0001);
        check({31'h0, irq}, 32'h0000_0000);
        chk(STATUS_OFS, 32'h0000_0000);
        // Reload from the capture register instead of wrapping.
        v = $urandom & 32'h0000_ffff;
        wr(CAPTURE_RELOAD_REG_OFS, v);
        wr(CORE_CTRL_OFS, 32'h0000_0089);
        wr(CORE_CNT_OFS, 32'h0000_ffff);
        i_pins.pulse(CORP, 1);
        chk(CORE_CNT_OFS, v);
        // Latch changes clock the aux timer, one count per core overflow.
        wr(CORE_CTRL_OFS, 32'h0000_0009);
        wr(AUX_CNT_OFS, 32'h0000_0000);
        wr(AUX_CTRL_OFS, 32'h0000_0009);
        for (int i = 0; i < 3; i++) begin
            wr(CORE_CNT_OFS, 32'h0000_ffff);
            i_pins.pulse(CORP, 1);
        end
        chk(AUX_CNT_OFS, 32'h0000_0003);
        // Aux down by software only, then a rising capture edge with clear.
        wr(AUX_CTRL_OFS, 32'h0000_0007);
        wr(AUX_CNT_OFS, 32'h0000_0005);
        i_pins.pulse(AUXP, 2);
        chk(AUX_CNT_OFS, 32'h0000_0003);
        wr(CAP_CTRL_OFS, 32'h0000_0005);
        i_pins.pulse(CAPP, 1);
        chk(CAPTURE_RELOAD_REG_OFS, 32'h0000_0003);
        chk(AUX_CNT_OFS, 32'h0000_0000);
        chk(STATUS_OFS, 32'h0000_0003);
        // Peer line triggers, every mode, with the aux timer stopped.
        wr(AUX_CTRL_OFS, 32'h0000_0000);
        for (int t = 1; t < 4; t++) begin
            v = $urandom & 32'h0000_ffff;
            wr(AUX_CNT_OFS, v);
            wr(CAP_CTRL_OFS, t << F_CAP_TRIG_LO);
            i_pins.set_level(PCNT + (t == 2), ~i_pins.pins[PCNT + (t == 2)]);
            chk(CAPTURE_RELOAD_REG_OFS, v);
        end
        // Aux down from the prescaler underflows at once and sets its sticky bit.
        wr(AUX_CNT_OFS, 32'h0000_0000);
        wr(AUX_CTRL_OFS, 32'h0000_0003);
        wr(AUX_CTRL_OFS, 32'h0000_0000);
        chk(STATUS_OFS, 32'h0000_0007);
        // Falling edge selected: the rising edge must leave the register alone.
        wr(CAP_CTRL_OFS, 32'h0000_0002);
        i_pins.set_level(CAPP, 1'b1);
        chk(CAPTURE_RELOAD_REG_OFS, v);
        wr(AUX_CNT_OFS, 32'h0000_5a5a);
        i_pins.set_level(CAPP, 1'b0);
        chk(CAPTURE_RELOAD_REG_OFS, 32'h0000_5a5a);
        // Prescaled core: one step per 2 << exp clocks at best.
        for (int e = 0; e < 3; e++) begin
            p = 2 << e;
            wr(CORE_CNT_OFS, 32'h0000_0000);
            wr(CORE_CTRL_OFS, 32'h0000_0001 | (e << F_PSC_LO));
            t0 = cyc;
            repeat (64) @(posedge aclk);
            wr(CORE_CTRL_OFS, 32'h0000_0000);
            t0 = cyc - t0;
            axi_read({24'h00_0000, CORE_CNT_OFS}, rd, rsp);
            check(32'(rd * p + p >= 64 && rd * p <= t0 + p), 32'h0000_0001);
        end
        close_out();
    end
endmodule : dual_timer_capture_reload_test
